// ### common/wpr_pkg.sv
package wpr_pkg;
    // Register offsets
    localparam logic [7:0] WDT_CTRL_OFF = 8'h8f;
    localparam logic [7:0] PWR_CTRL_OFF = 8'h87;
    localparam logic [7:0] PORT_STAT_OFF = 8'h80;
    localparam logic [7:0] STACK_STAT_OFF = 8'h81;
    // Watchdog control field positions
    localparam int WDT_EN_POS = 7;
    localparam int WDT_CLR_POS = 6;
    localparam int WDT_IDLE_POS = 5;
    localparam int PS_HI_POS = 2;
    localparam int PS_LO_POS = 0;
    // Power control field positions
    localparam int PWR_KEEP_POS = 4;
    localparam int PWR_DOWN_POS = 1;
    localparam int PWR_IDLE_POS = 0;
    // Reset values
    localparam logic [7:0] WDT_CTRL_RST = 8'h00;
    localparam logic [7:0] PWR_CTRL_RST = 8'h00;
    localparam logic [7:0] PORT_RST = 8'hff;
    localparam logic [7:0] STACK_RST = 8'h07;
    // Timing: twelve oscillator periods per machine cycle, two per core clock
    localparam int OSC_PER_MCYC = 12;
    localparam int OSC_PER_CLK = 2;
    localparam int CLK_PER_MCYC = OSC_PER_MCYC / OSC_PER_CLK;
    localparam logic [2:0] MCYC_LAST = 3'(CLK_PER_MCYC - 1);
    localparam logic [2:0] STATE5_PHASE2 = 3'h4;
    localparam int TIMER_BITS = 14;
    localparam int RST_MIN_MCYC = 2;
    localparam logic [1:0] RST_HOLD_LAST = 2'(RST_MIN_MCYC - 1);
    // Power states
    typedef enum logic [2:0] {
        PWR_RUN = 3'h1,
        PWR_IDLE = 3'h2,
        PWR_DOWN = 3'h4
    } wpr_pwr_t;
endpackage

// ### rtl/wpr_top.sv
`timescale 1ns/1ns
module wpr_top (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic rst_pin,
    input wire logic any_irq,
    input wire logic [7:0] ext_irq_lines,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic sys_reset,
    output logic cpu_clk_en,
    output logic periph_clk_en,
    output logic osc_run,
    output logic wdt_timeout
);
    // Reset release synchroniser
    logic [1:0] rstn_sync_r;
    logic rstn;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rstn_sync_r <= 2'h0;
        end else begin
            rstn_sync_r <= {rstn_sync_r[0], 1'b1};
        end
    end
    assign rstn = rstn_sync_r[1];

    // Pin synchronisers for reset pin and interrupt lines
    logic pin_meta_r, pin_sync_r;
    logic [7:0] irq_meta_r, irq_sync_r;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pin_meta_r <= 1'b0;
            pin_sync_r <= 1'b0;
            irq_meta_r <= 8'h00;
            irq_sync_r <= 8'h00;
        end else begin
            pin_meta_r <= rst_pin;
            pin_sync_r <= pin_meta_r;
            irq_meta_r <= ext_irq_lines;
            irq_sync_r <= irq_meta_r;
        end
    end

    // State registers
    logic [2:0] phase_r, phase_nxt;
    logic [1:0] pin_hold_r, pin_hold_nxt;
    logic [1:0] wd_hold_r, wd_hold_nxt;
    logic wd_rst_r, wd_rst_nxt;
    logic sys_rst_r, sys_rst_nxt;
    logic [7:0] wdt_ctrl_r, wdt_ctrl_nxt;
    logic [7:0] pwr_ctrl_r, pwr_ctrl_nxt;
    logic [7:0] port_r, port_nxt;
    logic [7:0] stack_r, stack_nxt;
    logic [7:0] pre_r, pre_nxt;
    logic [13:0] tmr_r, tmr_nxt;
    logic clr_pend_r, clr_pend_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic tout_r, tout_nxt;
    wpr_pkg::wpr_pwr_t pwr_r, pwr_nxt;
    logic cpu_en_r, cpu_en_nxt; // Registered processor clock enable
    logic awake_r, awake_nxt; // Registered peripheral and oscillator enable
    // Combinational helpers
    logic mcyc_end;
    logic pre_tick;
    logic wdt_run;
    logic [2:0] ps_sel;
    logic [7:0] pre_mask;

    // Prescale code to divider mask: 000=2,010=4,001=8,011=16, then 32..256
    always_comb begin
        ps_sel = wdt_ctrl_r[wpr_pkg::PS_HI_POS:wpr_pkg::PS_LO_POS];
        case (ps_sel)
            3'h0: pre_mask = 8'h01;
            3'h2: pre_mask = 8'h03;
            3'h1: pre_mask = 8'h07;
            3'h3: pre_mask = 8'h0f;
            3'h4: pre_mask = 8'h1f;
            3'h5: pre_mask = 8'h3f;
            3'h6: pre_mask = 8'h7f;
            default: pre_mask = 8'hff;
        endcase
    end

    // Next-state logic
    always_comb begin
        phase_nxt = phase_r;
        pin_hold_nxt = pin_hold_r;
        wd_hold_nxt = wd_hold_r;
        wd_rst_nxt = wd_rst_r;
        sys_rst_nxt = sys_rst_r;
        wdt_ctrl_nxt = wdt_ctrl_r;
        pwr_ctrl_nxt = pwr_ctrl_r;
        port_nxt = port_r;
        stack_nxt = stack_r;
        pre_nxt = pre_r;
        tmr_nxt = tmr_r;
        clr_pend_nxt = clr_pend_r;
        rdata_nxt = 8'h00;
        tout_nxt = 1'b0;
        pwr_nxt = pwr_r;
        // Machine cycle of six core clocks (each core clock is two osc periods)
        mcyc_end = (phase_r == wpr_pkg::MCYC_LAST);
        phase_nxt = mcyc_end ? 3'h0 : phase_r + 3'h1;
        // Watchdog runs when enabled, not in power-down, and in idle only if allowed
        wdt_run = wdt_ctrl_r[wpr_pkg::WDT_EN_POS] && (pwr_r != wpr_pkg::PWR_DOWN) &&
                  ((pwr_r != wpr_pkg::PWR_IDLE) || wdt_ctrl_r[wpr_pkg::WDT_IDLE_POS]);
        pre_tick = 1'b0;
        // Reset pin: sampled once per machine cycle; glitches reset the count
        if (phase_r == wpr_pkg::STATE5_PHASE2) begin
            if (!pin_sync_r) begin
                pin_hold_nxt = 2'h0;
            end else if (pin_hold_r != wpr_pkg::RST_HOLD_LAST + 2'h1) begin
                pin_hold_nxt = pin_hold_r + 2'h1;
            end
        end
        // Watchdog-generated reset stretched over two machine cycles
        if (wd_rst_r && mcyc_end) begin
            if (wd_hold_r == wpr_pkg::RST_HOLD_LAST) begin
                wd_rst_nxt = 1'b0;
                wd_hold_nxt = 2'h0;
            end else begin
                wd_hold_nxt = wd_hold_r + 2'h1;
            end
        end
        sys_rst_nxt = wd_rst_r || (pin_hold_r == wpr_pkg::RST_HOLD_LAST + 2'h1);
        if (sys_rst_r) begin
            // Reset values of the controlled registers
            wdt_ctrl_nxt = wpr_pkg::WDT_CTRL_RST;
            pwr_ctrl_nxt = (wpr_pkg::PWR_CTRL_RST & ~(8'h01 << wpr_pkg::PWR_KEEP_POS)) |
                           (pwr_ctrl_r & (8'h01 << wpr_pkg::PWR_KEEP_POS));
            port_nxt = wpr_pkg::PORT_RST;
            stack_nxt = wpr_pkg::STACK_RST;
            pre_nxt = 8'h00;
            tmr_nxt = 14'h0000;
            clr_pend_nxt = 1'b0;
            pwr_nxt = wpr_pkg::PWR_RUN;
        end else begin
            // Watchdog divider chain, one prescaler step per machine cycle
            if (clr_pend_r && mcyc_end) begin
                pre_nxt = 8'h00;
                tmr_nxt = 14'h0000;
                clr_pend_nxt = 1'b0;
                wdt_ctrl_nxt[wpr_pkg::WDT_CLR_POS] = 1'b0;
            end else if (wdt_run && mcyc_end) begin
                pre_tick = ((pre_r & pre_mask) == pre_mask);
                pre_nxt = pre_tick ? 8'h00 : pre_r + 8'h01;
                if (pre_tick) begin
                    tmr_nxt = tmr_r + 14'h0001;
                    if (tmr_r == {wpr_pkg::TIMER_BITS{1'b1}}) begin
                        tout_nxt = 1'b1;
                        wd_rst_nxt = 1'b1;
                        wd_hold_nxt = 2'h0;
                    end
                end
            end
            // Power state machine
            case (pwr_r)
                wpr_pkg::PWR_RUN: begin
                    if (pwr_ctrl_r[wpr_pkg::PWR_DOWN_POS]) begin
                        pwr_nxt = wpr_pkg::PWR_DOWN;
                    end else if (pwr_ctrl_r[wpr_pkg::PWR_IDLE_POS]) begin
                        pwr_nxt = wpr_pkg::PWR_IDLE;
                    end
                end
                wpr_pkg::PWR_IDLE: begin
                    if (any_irq) begin
                        pwr_nxt = wpr_pkg::PWR_RUN;
                        pwr_ctrl_nxt[wpr_pkg::PWR_IDLE_POS] = 1'b0;
                    end
                end
                wpr_pkg::PWR_DOWN: begin
                    if (irq_sync_r != 8'h00) begin
                        pwr_nxt = wpr_pkg::PWR_RUN;
                        pwr_ctrl_nxt[wpr_pkg::PWR_DOWN_POS] = 1'b0;
                    end
                end
                default: pwr_nxt = wpr_pkg::PWR_RUN;
            endcase
            // Register writes; a clear request is held until the next machine cycle
            if (reg_wr) begin
                if (reg_addr == wpr_pkg::WDT_CTRL_OFF) begin
                    wdt_ctrl_nxt = reg_wdata & 8'he7;
                    if (reg_wdata[wpr_pkg::WDT_CLR_POS]) begin
                        clr_pend_nxt = 1'b1;
                    end
                end else if (reg_addr == wpr_pkg::PWR_CTRL_OFF) begin
                    pwr_ctrl_nxt = reg_wdata;
                end else if (reg_addr == wpr_pkg::PORT_STAT_OFF) begin
                    port_nxt = reg_wdata;
                end else if (reg_addr == wpr_pkg::STACK_STAT_OFF) begin
                    stack_nxt = reg_wdata;
                end
            end
        end
        // Clock enables follow the next power state, so outputs come from flops
        cpu_en_nxt = (pwr_nxt == wpr_pkg::PWR_RUN);
        awake_nxt = (pwr_nxt != wpr_pkg::PWR_DOWN);
        // Register reads, data valid in the following cycle
        if (reg_rd) begin
            if (reg_addr == wpr_pkg::WDT_CTRL_OFF) begin
                rdata_nxt = wdt_ctrl_r;
            end else if (reg_addr == wpr_pkg::PWR_CTRL_OFF) begin
                rdata_nxt = pwr_ctrl_r;
            end else if (reg_addr == wpr_pkg::PORT_STAT_OFF) begin
                rdata_nxt = port_r;
            end else if (reg_addr == wpr_pkg::STACK_STAT_OFF) begin
                rdata_nxt = stack_r;
            end else begin
                rdata_nxt = 8'h00;
            end
        end
    end

    // Registering of all state except the synchronisers, frozen while clock enable is low
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            phase_r <= 3'h0;
            pin_hold_r <= 2'h0;
            wd_hold_r <= 2'h0;
            wd_rst_r <= 1'b0;
            sys_rst_r <= 1'b0;
            wdt_ctrl_r <= wpr_pkg::WDT_CTRL_RST;
            pwr_ctrl_r <= wpr_pkg::PWR_CTRL_RST;
            port_r <= wpr_pkg::PORT_RST;
            stack_r <= wpr_pkg::STACK_RST;
            pre_r <= 8'h00;
            tmr_r <= 14'h0000;
            clr_pend_r <= 1'b0;
            rdata_r <= 8'h00;
            tout_r <= 1'b0;
            pwr_r <= wpr_pkg::PWR_RUN;
            cpu_en_r <= 1'b1;
            awake_r <= 1'b1;
        end else if (clk_en) begin
            phase_r <= phase_nxt;
            pin_hold_r <= pin_hold_nxt;
            wd_hold_r <= wd_hold_nxt;
            wd_rst_r <= wd_rst_nxt;
            sys_rst_r <= sys_rst_nxt;
            wdt_ctrl_r <= wdt_ctrl_nxt;
            pwr_ctrl_r <= pwr_ctrl_nxt;
            port_r <= port_nxt;
            stack_r <= stack_nxt;
            pre_r <= pre_nxt;
            tmr_r <= tmr_nxt;
            clr_pend_r <= clr_pend_nxt;
            rdata_r <= rdata_nxt;
            tout_r <= tout_nxt;
            pwr_r <= pwr_nxt;
            cpu_en_r <= cpu_en_nxt;
            awake_r <= awake_nxt;
        end
    end

    // Outputs straight from flip-flops
    assign reg_rdata = rdata_r;
    assign sys_reset = sys_rst_r;
    assign cpu_clk_en = cpu_en_r;
    assign periph_clk_en = awake_r;
    assign osc_run = awake_r;
    assign wdt_timeout = tout_r;

    // Assertions
    a_timeout_resets: assert property (@(posedge core_clk) disable iff (!rstn)
        (clk_en && tout_nxt) |=> wd_rst_r) else $error("timeout gave no reset");
    a_reset_disables: assert property (@(posedge core_clk) disable iff (!rstn)
        (clk_en && sys_rst_r) |=> !wdt_ctrl_r[wpr_pkg::WDT_EN_POS])
        else $error("watchdog enabled after reset");
    a_reset_zeroes: assert property (@(posedge core_clk) disable iff (!rstn)
        (clk_en && sys_rst_r) |=> (tmr_r == 14'h0000 && pre_r == 8'h00))
        else $error("counter not zero after reset");
    a_clear_selfclr: assert property (@(posedge core_clk) disable iff (!rstn || !clk_en)
        clr_pend_r |-> ##[0:12] !wdt_ctrl_r[wpr_pkg::WDT_CLR_POS])
        else $error("clear bit stuck");
    a_disabled_frozen: assert property (@(posedge core_clk) disable iff (!rstn)
        (!wdt_ctrl_r[wpr_pkg::WDT_EN_POS] && !clr_pend_r && !sys_rst_r) |=>
        $stable(tmr_r)) else $error("disabled watchdog counted");
    a_idle_stops: assert property (@(posedge core_clk) disable iff (!rstn)
        (pwr_r == wpr_pkg::PWR_IDLE && !wdt_ctrl_r[wpr_pkg::WDT_IDLE_POS] &&
        !clr_pend_r && !sys_rst_r) |=> $stable(pre_r))
        else $error("watchdog ran in idle");
    a_wd_hold_long: assert property (@(posedge core_clk) disable iff (!rstn)
        $rose(wd_rst_r) |-> wd_rst_r [*7]) else $error("watchdog reset too short");
    a_pd_clocks: assert property (@(posedge core_clk) disable iff (!rstn)
        (clk_en && !sys_rst_r && pwr_r == wpr_pkg::PWR_RUN &&
        pwr_ctrl_r[wpr_pkg::PWR_DOWN_POS]) |=> (!osc_run && !periph_clk_en && !cpu_clk_en))
        else $error("clock running in power-down");
    a_idle_cpu: assert property (@(posedge core_clk) disable iff (!rstn)
        (clk_en && !sys_rst_r && pwr_r == wpr_pkg::PWR_RUN &&
        pwr_ctrl_r[wpr_pkg::PWR_IDLE_POS] && !pwr_ctrl_r[wpr_pkg::PWR_DOWN_POS]) |=>
        (!cpu_clk_en && periph_clk_en)) else $error("idle clock gating wrong");
    a_phase_wrap: assert property (@(posedge core_clk) disable iff (!rstn)
        (clk_en && mcyc_end) |=> (phase_r == 3'h0)) else $error("machine cycle wrong");
    c_timeout: cover property (@(posedge core_clk) disable iff (!rstn) tout_r);
    c_idle_wake: cover property (@(posedge core_clk) disable iff (!rstn)
        pwr_r == wpr_pkg::PWR_IDLE ##1 pwr_r == wpr_pkg::PWR_RUN);
    c_pd_wake: cover property (@(posedge core_clk) disable iff (!rstn)
        pwr_r == wpr_pkg::PWR_DOWN ##1 pwr_r == wpr_pkg::PWR_RUN);
    c_pin_reset: cover property (@(posedge core_clk) disable iff (!rstn)
        sys_rst_r && !wd_rst_r);
endmodule

// ### sim/watchdog_power_reset_control_tb_top.sv
`timescale 1ns/1ns
module watchdog_power_reset_control_tb_top;
    // Bench rows: write first when wr is set, then read back and compare
    typedef struct {logic wr; logic [7:0] a; logic [7:0] d; logic [7:0] e;} wpr_row_t;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic clk_en = 1'b1;
    logic rst_pin = 1'b0;
    logic any_irq = 1'b0;
    logic [7:0] ext_irq_lines = 8'h00;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic sys_reset, cpu_clk_en, periph_clk_en, osc_run, wdt_timeout;
    int fails = 0;
    int samples_checked = 0;
    int cycles = 0;
    int n;
    logic glitch_hit;
    wpr_row_t rows[10] = '{
        '{1'b0, 8'h8f, 8'h00, 8'h00}, '{1'b0, 8'h87, 8'h00, 8'h00},
        '{1'b0, 8'h80, 8'h00, 8'hff}, '{1'b0, 8'h81, 8'h00, 8'h07},
        '{1'b0, 8'h10, 8'h00, 8'h00}, '{1'b1, 8'h8f, 8'h27, 8'h27},
        '{1'b1, 8'h8f, 8'h3d, 8'h25}, '{1'b1, 8'h8f, 8'h00, 8'h00},
        '{1'b1, 8'h10, 8'h5a, 8'h00}, '{1'b1, 8'h87, 8'h10, 8'h10}};

    wpr_top u_dut (.core_clk(core_clk), .resetn(resetn), .clk_en(clk_en), .rst_pin(rst_pin),
        .any_irq(any_irq), .ext_irq_lines(ext_irq_lines), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .sys_reset(sys_reset), .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
        .osc_run(osc_run), .wdt_timeout(wdt_timeout));

    // 125 MHz core clock
    always #4 core_clk = ~core_clk;

    // Compare and count
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask

    // One-cycle register write
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    // One-cycle read, data sampled in the following cycle only
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input string msg);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        chk(reg_rdata, e, msg);
    endtask

    // Selects an output level by index
    function automatic logic pick(input int w);
        case (w)
            0: return sys_reset;
            1: return cpu_clk_en;
            2: return osc_run;
            default: return periph_clk_en;
        endcase
    endfunction

    // Bounded wait for a level, then compare it
    task automatic await(input int w, input logic lvl, input int lim, input string msg);
        n = 0;
        while (pick(w) !== lvl && n < lim) begin
            @(negedge core_clk);
            n++;
        end
        chk({7'h00, pick(w)}, {7'h00, lvl}, msg);
    endtask

    // Verdict and end of run
    task automatic close_out();
        $display("fails %0d samples_checked %0d", fails, samples_checked);
        if (fails == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Hang guard
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 6000) begin
            fails++;
            $display("mismatch at %0t: run did not finish", $time);
            close_out();
        end
    end

    // Short run is far below 16384 x 2 machine cycles, so no overflow may show
    always @(negedge core_clk) begin
        if (resetn && wdt_timeout !== 1'b0) begin
            fails++;
            $display("mismatch at %0t: early watchdog overflow", $time);
        end
    end

    initial begin
        repeat (2) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge core_clk);
        // Table of reset values and read-back
        foreach (rows[i]) begin
            if (rows[i].wr) begin
                wr(rows[i].a, rows[i].d);
            end
            rd(rows[i].a, rows[i].e, "register row");
        end
        // Every prescale code is stored as written
        for (int k = 0; k < 8; k++) begin
            wr(8'h8f, {5'h00, 3'(k)});
            rd(8'h8f, {5'h00, 3'(k)}, "prescale code");
        end
        // Enable, then clear: the clear bit drops by itself within a machine cycle
        wr(8'h8f, 8'h80);
        wr(8'h8f, 8'hc0);
        repeat (8) @(posedge core_clk);
        rd(8'h8f, 8'h80, "clear bit self clears");
        // Idle stops the processor clock only; an interrupt wakes it
        wr(8'h87, 8'h11);
        await(1, 1'b0, 3, "idle cpu clock");
        chk({7'h00, periph_clk_en}, 8'h01, "idle peripheral clock");
        @(posedge core_clk);
        any_irq <= 1'b1;
        await(1, 1'b1, 4, "idle wake");
        @(posedge core_clk);
        any_irq <= 1'b0;
        rd(8'h87, 8'h10, "idle bit after wake");
        // Power-down stops all clocks; an external line wakes it
        wr(8'h87, 8'h12);
        await(2, 1'b0, 3, "power-down oscillator");
        chk({6'h00, periph_clk_en, cpu_clk_en}, 8'h00, "power-down clocks");
        @(posedge core_clk);
        ext_irq_lines <= 8'h08;
        await(2, 1'b1, 8, "power-down wake");
        chk({7'h00, periph_clk_en}, 8'h01, "wake peripheral clock");
        @(posedge core_clk);
        ext_irq_lines <= 8'h00;
        rd(8'h87, 8'h10, "power-down bit after wake");
        // One-cycle glitch on the reset pin is ignored
        @(posedge core_clk);
        rst_pin <= 1'b1;
        @(posedge core_clk);
        rst_pin <= 1'b0;
        glitch_hit = 1'b0;
        repeat (24) begin
            @(negedge core_clk);
            glitch_hit = glitch_hit | (sys_reset !== 1'b0);
        end
        chk({7'h00, glitch_hit}, 8'h00, "glitch ignored");
        // Port and stack take new values first, so the reset has something to undo
        wr(8'h80, 8'h3c);
        rd(8'h80, 8'h3c, "port write");
        wr(8'h81, 8'h5a);
        rd(8'h81, 8'h5a, "stack write");
        // Sustained pin reset while idle: exits idle, clears watchdog, keeps bit 4
        wr(8'h87, 8'h11);
        @(posedge core_clk);
        rst_pin <= 1'b1;
        await(0, 1'b1, 30, "pin reset");
        chk({7'h00, n >= 6}, 8'h01, "pin reset needs two samples");
        await(1, 1'b1, 4, "reset exits idle");
        @(posedge core_clk);
        rst_pin <= 1'b0;
        await(0, 1'b0, 20, "pin reset release");
        repeat (3) @(posedge core_clk);
        rd(8'h87, 8'h10, "power control after reset");
        rd(8'h8f, 8'h00, "watchdog off after reset");
        rd(8'h80, 8'hff, "port after reset");
        rd(8'h81, 8'h07, "stack after reset");
        // Clock enable low freezes the block, so a write in that time is lost
        @(posedge core_clk);
        clk_en <= 1'b0;
        wr(8'h81, 8'h3c);
        clk_en <= 1'b1;
        rd(8'h81, 8'h07, "write dropped while frozen");
        close_out();
    end
endmodule
